// ### design/cmf_pkg.sv
`default_nettype none
package cmf_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // permanent dominant limit, 2 ms
    localparam int DOM_LIMIT_NS = 2000000;
    localparam int DOM_LIMIT_CYC = DOM_LIMIT_NS / CLK_PERIOD_NS;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [3:0] CRC_LAST = 4'he;
    localparam logic [3:0] EOF_LAST = 4'h6;
    localparam logic [3:0] IFS_LAST = 4'h2;
    localparam logic [14:0] CRC_POLY = 15'h4599;
    localparam logic [14:0] CRC_INIT = 15'h0000;

    typedef enum logic [2:0] {
        CMF_NORMAL = 3'b000,
        CMF_LOOP = 3'b001,
        CMF_MON = 3'b010,
        CMF_SLEEP = 3'b011,
        CMF_INIT = 3'b100
    } cmf_mode_t;

    localparam cmf_mode_t MODE_RESET = CMF_INIT;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_BODY = 3'b001,
        TX_CRC = 3'b010,
        TX_CDEL = 3'b011,
        TX_ACK = 3'b100,
        TX_ADEL = 3'b101,
        TX_EOF = 3'b110,
        TX_IFS = 3'b111
    } cmf_tx_st_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_BODY = 3'b001,
        RX_CRC = 3'b010,
        RX_CDEL = 3'b011,
        RX_ACK = 3'b100,
        RX_ADEL = 3'b101,
        RX_EOF = 3'b110,
        RX_IFS = 3'b111
    } cmf_rx_st_t;

    typedef struct packed {
        logic valid;
        logic bit_val;
        logic last;
    } cmf_tx_src_t;

    typedef struct packed {
        logic valid;
        logic bit_val;
        logic sof;
        logic frame_ok;
        logic frame_err;
    } cmf_rx_out_t;

    function automatic cmf_mode_t cmf_decode_mode(input logic [2:0] v);
        if (v[2])
        begin
            return CMF_INIT;
        end
        return cmf_mode_t'(v);
    endfunction : cmf_decode_mode

    function automatic logic [14:0] cmf_crc_next(input logic [14:0] c, input logic b);
        logic [14:0] n;
        n = {c[13:0], 1'b0};
        if (b ^ c[14])
        begin
            n = n ^ CRC_POLY;
        end
        return n;
    endfunction : cmf_crc_next
endpackage : cmf_pkg
`default_nettype wire

// ### design/cmf_core.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - reset, or mode value 1xx, selects initialization mode
// - configuration and filter writes accepted only in initialization mode
// - entering initialization resets transmit and receive state machines
// - error counters held at zero during initialization
// - mode 000 is normal: transmit, receive, acknowledge
// - mode 001 loops transmitter to receiver, bus untouched and ignored
// - loopback frames reach receive path as if from remote node
// - mode 010 monitor drives no dominant bit at all
// - monitor clears error counters and keeps them inactive
// - monitor still receives frames normally
// - independent counter shuts transmitter off past 2 ms dominant
// - mode 011 sleeps only when bus idle and queue empty
// - mode change deferred until own transmission completes
// - mode change deferred until receiver sees interframe gap
// - host interface stays usable while asleep
// - sleep ends on mode write, or dominant bus with wake enable
// - frame that woke the device may be lost
// - nrz bits, 0 dominant, 1 recessive
// - stuff opposite bit after five equal, receivers drop it
// - stuffing from sof through crc sequence only
// - 15-bit crc over sof to data, stuff bits excluded
// - transmitter sends recessive ack slot, good receivers drive dominant
// - ack delimiter always recessive
// - dominant in third intermission bit is a new sof
// - crc delimiter always recessive
// - end of frame is seven recessive bits
// - intermission is three recessive bits
module cmf_core #(
    parameter int DOM_LIMIT = cmf_pkg::DOM_LIMIT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host control
    input wire logic mode_wr,
    input wire logic [2:0] mode_wdata,
    input wire logic bus_activity_wake_enable,
    input wire logic tx_queue_empty,
    output cmf_pkg::cmf_mode_t mode_active,
    output cmf_pkg::cmf_mode_t mode_requested,
    output logic mode_pending,
    output logic cfg_wr_enable,
    output logic err_ctr_hold,
    // bit timing
    input wire logic bit_tick,
    // bus
    input wire logic can_rx,
    output logic can_tx,
    output logic tx_shutoff,
    // frame streams
    input wire cmf_pkg::cmf_tx_src_t tx_src,
    output logic tx_take,
    output logic tx_done,
    input wire logic rx_fields_done,
    output cmf_pkg::cmf_rx_out_t rx_out
);
    import cmf_pkg::*;

    localparam int DW = $clog2(DOM_LIMIT + 1);
    localparam logic [DW-1:0] DOM_LIM = DW'(DOM_LIMIT);

    typedef struct packed {
        cmf_mode_t mode;
        cmf_mode_t req;
        logic pending;
        cmf_tx_st_t tx_st;
        cmf_rx_st_t rx_st;
        logic [3:0] tx_cnt;
        logic [3:0] rx_cnt;
        logic [2:0] tx_run;
        logic [2:0] rx_run;
        logic tx_last;
        logic rx_last;
        logic [14:0] tx_crc;
        logic [14:0] rx_crc;
        logic tx_lvl;
        logic pin;
        logic [DW-1:0] dom;
        logic shutoff;
        logic take;
        logic done;
        cmf_rx_out_t rx;
        logic cfg_en;
        logic err_hold;
    } cmf_state_t;

    cmf_state_t q;
    cmf_state_t d;

    always_comb
    begin
        logic rx_lvl;
        logic quiet;
        logic tx_go;
        logic rx_go;
        logic tb;
        rx_lvl = 1'b1;
        quiet = 1'b0;
        tx_go = 1'b0;
        rx_go = 1'b0;
        tb = 1'b1;
        d = q;
        d.take = 1'b0;
        d.done = 1'b0;
        d.rx = '0;
        // internal loop; own frames reach receive path
        rx_lvl = (q.mode == CMF_LOOP) ? q.tx_lvl : can_rx;
        tx_go = ((q.mode == CMF_NORMAL) || (q.mode == CMF_LOOP)) && !q.shutoff;
        rx_go = (q.mode == CMF_NORMAL) || (q.mode == CMF_LOOP) || (q.mode == CMF_MON);
        // quiet only with tx idle and rx in gap
        quiet = (q.tx_st == TX_IDLE) && ((q.rx_st == RX_IDLE) || (q.rx_st == RX_IFS));

        if (q.pending && quiet)
        begin
            // sleep also needs a truly idle bus and empty queue
            if ((q.req != CMF_SLEEP) || ((q.rx_st == RX_IDLE) && tx_queue_empty))
            begin
                d.mode = q.req;
                d.pending = 1'b0;
            end
        end
        // wake on dominant level; that frame is not chased
        if ((q.mode == CMF_SLEEP) && bus_activity_wake_enable && !can_rx)
        begin
            d.mode = CMF_MON;
            d.req = CMF_MON;
            d.pending = 1'b0;
        end
        // top bit forces init; any write of a mode other than sleep ends sleep via pending
        if (mode_wr)
        begin
            d.req = cmf_decode_mode(mode_wdata);
            d.pending = 1'b1;
        end

        if (bit_tick && tx_go)
        begin
            unique case (q.tx_st)
                TX_IDLE:
                begin
                    // start only on an idle bus, data begins with sof
                    if (tx_src.valid && (q.rx_st == RX_IDLE))
                    begin
                        d.take = 1'b1;
                        d.tx_lvl = tx_src.bit_val;
                        d.tx_run = 3'h1;
                        d.tx_last = tx_src.bit_val;
                        d.tx_crc = cmf_crc_next(CRC_INIT, tx_src.bit_val);
                        d.tx_st = TX_BODY;
                    end
                end
                TX_BODY, TX_CRC, TX_CDEL:
                begin
                    // stuff bit, kept out of the crc
                    if (q.tx_run == STUFF_RUN)
                    begin
                        d.tx_lvl = ~q.tx_last;
                        d.tx_last = ~q.tx_last;
                        d.tx_run = 3'h1;
                    end
                    else if (q.tx_st == TX_BODY)
                    begin
                        if (tx_src.valid)
                        begin
                            tb = tx_src.bit_val;
                            d.take = 1'b1;
                            d.tx_lvl = tb;
                            d.tx_crc = cmf_crc_next(q.tx_crc, tb);
                            d.tx_run = (tb == q.tx_last) ? q.tx_run + 3'h1 : 3'h1;
                            d.tx_last = tb;
                            d.tx_cnt = 4'h0;
                            if (tx_src.last)
                            begin
                                d.tx_st = TX_CRC;
                            end
                        end
                        else
                        begin
                            // underrun mid frame cannot be repaired; give up
                            d.tx_lvl = 1'b1;
                            d.tx_st = TX_IDLE;
                        end
                    end
                    else if (q.tx_st == TX_CRC)
                    begin
                        tb = q.tx_crc[14];
                        d.tx_lvl = tb;
                        d.tx_crc = {q.tx_crc[13:0], 1'b0};
                        d.tx_run = (tb == q.tx_last) ? q.tx_run + 3'h1 : 3'h1;
                        d.tx_last = tb;
                        d.tx_cnt = q.tx_cnt + 4'h1;
                        if (q.tx_cnt == CRC_LAST)
                        begin
                            d.tx_st = TX_CDEL;
                        end
                    end
                    else
                    begin
                        d.tx_lvl = 1'b1;
                        d.tx_st = TX_ACK;
                    end
                end
                TX_ACK:
                begin
                    d.tx_lvl = 1'b1;
                    d.tx_st = TX_ADEL;
                end
                TX_ADEL:
                begin
                    d.tx_lvl = 1'b1;
                    d.tx_cnt = 4'h0;
                    d.tx_st = TX_EOF;
                end
                TX_EOF:
                begin
                    d.tx_lvl = 1'b1;
                    d.tx_cnt = q.tx_cnt + 4'h1;
                    if (q.tx_cnt == EOF_LAST)
                    begin
                        d.tx_cnt = 4'h0;
                        d.tx_st = TX_IFS;
                    end
                end
                TX_IFS:
                begin
                    d.tx_lvl = 1'b1;
                    d.tx_cnt = q.tx_cnt + 4'h1;
                    if (q.tx_cnt == IFS_LAST)
                    begin
                        d.tx_st = TX_IDLE;
                        d.done = 1'b1;
                    end
                end
            endcase
        end

        if (bit_tick && rx_go)
        begin
            unique case (q.rx_st)
                RX_IDLE:
                begin
                    if (!rx_lvl)
                    begin
                        d.rx.sof = 1'b1;
                        d.rx.valid = 1'b1;
                        d.rx.bit_val = 1'b0;
                        d.rx_crc = cmf_crc_next(CRC_INIT, 1'b0);
                        d.rx_run = 3'h1;
                        d.rx_last = 1'b0;
                        d.rx_st = RX_BODY;
                    end
                end
                RX_BODY, RX_CRC, RX_CDEL:
                begin
                    // drop stuff bit; equal level is a stuff error
                    if (q.rx_run == STUFF_RUN)
                    begin
                        d.rx_run = 3'h1;
                        d.rx_last = rx_lvl;
                        if (rx_lvl == q.rx_last)
                        begin
                            d.rx.frame_err = 1'b1;
                            d.rx_st = RX_IDLE;
                        end
                    end
                    else if (q.rx_st != RX_CDEL)
                    begin
                        // remainder over data plus crc field ends at zero
                        d.rx_crc = cmf_crc_next(q.rx_crc, rx_lvl);
                        d.rx_run = (rx_lvl == q.rx_last) ? q.rx_run + 3'h1 : 3'h1;
                        d.rx_last = rx_lvl;
                        d.rx_cnt = q.rx_cnt + 4'h1;
                        if (q.rx_st == RX_BODY)
                        begin
                            d.rx_cnt = 4'h1;
                            if (rx_fields_done)
                            begin
                                d.rx_st = RX_CRC;
                            end
                            else
                            begin
                                d.rx.valid = 1'b1;
                                d.rx.bit_val = rx_lvl;
                            end
                        end
                        else if (q.rx_cnt == CRC_LAST)
                        begin
                            d.rx_st = RX_CDEL;
                        end
                    end
                    else if (!rx_lvl)
                    begin
                        // dominant crc delimiter is a form error
                        d.rx.frame_err = 1'b1;
                        d.rx_st = RX_IDLE;
                    end
                    else
                    begin
                        d.rx_st = RX_ACK;
                        // ack only as a plain receiver in normal mode
                        if ((q.rx_crc == 15'h0000) && (q.mode == CMF_NORMAL) && (q.tx_st == TX_IDLE))
                        begin
                            d.tx_lvl = 1'b0;
                        end
                    end
                end
                RX_ACK:
                begin
                    if (q.tx_st == TX_IDLE)
                    begin
                        d.tx_lvl = 1'b1;
                    end
                    d.rx_st = RX_ADEL;
                end
                RX_ADEL:
                begin
                    d.rx_cnt = 4'h0;
                    d.rx_st = RX_EOF;
                    if (!rx_lvl || (q.rx_crc != 15'h0000))
                    begin
                        d.rx.frame_err = 1'b1;
                    end
                    else
                    begin
                        d.rx.frame_ok = 1'b1;
                    end
                end
                RX_EOF:
                begin
                    d.rx_cnt = q.rx_cnt + 4'h1;
                    if (q.rx_cnt == EOF_LAST)
                    begin
                        d.rx_cnt = 4'h0;
                        d.rx_st = RX_IFS;
                    end
                end
                RX_IFS:
                begin
                    d.rx_cnt = q.rx_cnt + 4'h1;
                    if (q.rx_cnt == IFS_LAST)
                    begin
                        d.rx_st = RX_IDLE;
                        // third intermission bit dominant is sof
                        if (!rx_lvl)
                        begin
                            d.rx.sof = 1'b1;
                            d.rx.valid = 1'b1;
                            d.rx.bit_val = 1'b0;
                            d.rx_crc = cmf_crc_next(CRC_INIT, 1'b0);
                            d.rx_run = 3'h1;
                            d.rx_last = 1'b0;
                            d.rx_st = RX_BODY;
                        end
                    end
                end
            endcase
        end

        // independent dominant watchdog, sticky until init
        d.dom = '0;
        if (!q.tx_lvl && (q.dom < DOM_LIM))
        begin
            d.dom = q.dom + 1'b1;
        end
        if (q.dom >= DOM_LIM)
        begin
            d.shutoff = 1'b1;
            d.tx_lvl = 1'b1;
            d.tx_st = TX_IDLE;
        end
        if (q.mode == CMF_INIT)
        begin
            d.tx_st = TX_IDLE;
            d.rx_st = RX_IDLE;
            d.tx_lvl = 1'b1;
            d.shutoff = 1'b0;
            d.dom = '0;
        end
        // only normal mode reaches the pin
        d.pin = (d.mode == CMF_NORMAL) ? d.tx_lvl : 1'b1;
        d.cfg_en = (d.mode == CMF_INIT);
        d.err_hold = (d.mode == CMF_INIT) || (d.mode == CMF_MON);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.mode <= MODE_RESET;
            q.req <= MODE_RESET;
            q.tx_lvl <= 1'b1;
            q.pin <= 1'b1;
            q.cfg_en <= 1'b1;
            q.err_hold <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // active and requested shown apart; host side never gated
    assign mode_active = q.mode;
    assign mode_requested = q.req;
    assign mode_pending = q.pending;
    assign cfg_wr_enable = q.cfg_en;
    assign err_ctr_hold = q.err_hold;
    assign can_tx = q.pin;
    assign tx_shutoff = q.shutoff;
    assign tx_take = q.take;
    assign tx_done = q.done;
    assign rx_out = q.rx;

    AST_INIT_AFTER_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> (q.mode == CMF_INIT) && q.cfg_en)
        else $error("not in init after reset");
    AST_CFG_GATE: assert property (@(posedge clk) disable iff (sys_rst)
        q.cfg_en == (q.mode == CMF_INIT))
        else $error("config gate differs from init mode");
    AST_INIT_RESETS_FSM: assert property (@(posedge clk) disable iff (sys_rst)
        (q.mode == CMF_INIT) |=> (q.tx_st == TX_IDLE) && (q.rx_st == RX_IDLE))
        else $error("state machines run in init");
    AST_ERR_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        ((q.mode == CMF_INIT) || (q.mode == CMF_MON)) |-> q.err_hold)
        else $error("error counters not held");
    AST_SILENT_MODES: assert property (@(posedge clk) disable iff (sys_rst)
        (q.mode != CMF_NORMAL) [*2] |-> q.pin)
        else $error("dominant driven outside normal mode");
    AST_DOM_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
        (q.dom == DOM_LIM) |=> q.shutoff && q.pin && (q.dom == '0))
        else $error("dominant timeout missed");
    AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(q.mode == CMF_SLEEP) |-> $past(q.rx_st == RX_IDLE) && $past(tx_queue_empty))
        else $error("sleep entered on busy bus");
    AST_DEFER_CHANGE: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(q.mode) && ($past(q.mode) != CMF_SLEEP) |->
            $past(q.tx_st) == TX_IDLE && $past(q.rx_st) inside {RX_IDLE, RX_IFS})
        else $error("mode changed mid frame");
    AST_STUFF_TX: assert property (@(posedge clk) disable iff (sys_rst)
        bit_tick && !q.shutoff && (q.mode inside {CMF_NORMAL, CMF_LOOP}) && (q.tx_run == STUFF_RUN)
            && (q.tx_st inside {TX_BODY, TX_CRC, TX_CDEL}) && (q.dom < DOM_LIM)
            |=> (q.tx_lvl != $past(q.tx_last)) && (q.tx_run == 3'h1))
        else $error("stuff bit missing");
    AST_ACK_DELIM: assert property (@(posedge clk) disable iff (sys_rst)
        bit_tick && (q.tx_st == TX_ADEL) && (q.mode inside {CMF_NORMAL, CMF_LOOP}) |=> q.tx_lvl)
        else $error("ack delimiter not recessive");

    COV_SLEEP: cover property (@(posedge clk) disable iff (sys_rst) $rose(q.mode == CMF_SLEEP));
    COV_WAKE: cover property (@(posedge clk) disable iff (sys_rst)
        (q.mode == CMF_SLEEP) ##1 (q.mode == CMF_MON));
    COV_RX_OK: cover property (@(posedge clk) disable iff (sys_rst) q.rx.frame_ok);
    COV_TX_DONE: cover property (@(posedge clk) disable iff (sys_rst) q.done && (q.mode == CMF_LOOP));
endmodule : cmf_core
`default_nettype wire

// ### testbench/cmf_node.sv
`timescale 1ns/1ps
`default_nettype none
module cmf_node (
    // clock and bit timing
    input wire logic clk,
    input wire logic bit_tick,
    // stuffed bits, msb first
    input wire logic go,
    input wire logic [15:0] bits,
    input wire logic [4:0] len,
    // bus drive
    output logic node_tx
);
    logic [15:0] sh_q;
    logic [4:0] cnt_q;
    initial
    begin
        sh_q = 16'h0;
        cnt_q = 5'h0;
        node_tx = 1'b1;
    end
    always @(posedge clk)
    begin
        if (go)
        begin
            sh_q <= bits;
            cnt_q <= len;
        end
        else if (bit_tick)
        begin
            // released node leaves bus recessive
            node_tx <= (cnt_q == 5'h0) | sh_q[15];
            sh_q <= {sh_q[14:0], 1'b1};
            cnt_q <= (cnt_q == 5'h0) ? 5'h0 : cnt_q - 5'h1;
        end
    end
endmodule : cmf_node
`default_nettype wire

// ### testbench/can_mode_control_and_framing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module can_mode_control_and_framing_tb;
    import cmf_pkg::*;
    logic clk, sys_rst, mode_wr, wake, tx_queue_empty, bit_tick, can_tx, tx_shutoff, tx_take, tx_done;
    logic mode_pending, cfg_wr_enable, err_ctr_hold, node_tx, go;
    logic [2:0] mode_wdata;
    logic [15:0] nbits;
    logic [4:0] nlen, tx_idx, tx_n;
    logic [2:0] rxn;
    cmf_mode_t mode_active, mode_requested;
    cmf_tx_src_t tx_src;
    cmf_rx_out_t rx_out;
    int tick_div, tcnt, n_errors, comparisons;
    wire logic can_rx;
    assign can_rx = can_tx & node_tx;
    cmf_core #(.DOM_LIMIT(50)) DUT (.clk(clk), .sys_rst(sys_rst), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
        .bus_activity_wake_enable(wake), .tx_queue_empty(tx_queue_empty), .mode_active(mode_active),
        .mode_requested(mode_requested), .mode_pending(mode_pending), .cfg_wr_enable(cfg_wr_enable),
        .err_ctr_hold(err_ctr_hold), .bit_tick(bit_tick), .can_rx(can_rx), .can_tx(can_tx),
        .tx_shutoff(tx_shutoff), .tx_src(tx_src), .tx_take(tx_take), .tx_done(tx_done),
        .rx_fields_done(rxn == 3'h7), .rx_out(rx_out));
    cmf_node NODE (.clk(clk), .bit_tick(bit_tick), .go(go), .bits(nbits), .len(nlen), .node_tx(node_tx));
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        tcnt <= (tcnt >= tick_div - 1) ? 0 : tcnt + 1;
        bit_tick <= tcnt == 0;
        if (tx_take)
            tx_idx <= tx_idx + 5'h1;
        tx_src.valid <= tx_idx < tx_n;
        tx_src.bit_val <= 1'b0;
        tx_src.last <= tx_idx == tx_n - 5'h1;
        // parser stand-in: sof plus six data bits, then the crc follows
        if (rx_out.sof)
            rxn <= 3'h1;
        else if (rx_out.valid)
            rxn <= rxn + 3'h1;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // returns just after the edge that sampled a bit tick
    task automatic tick();
        do @(posedge clk); while (bit_tick !== 1'b1);
        #1;
    endtask : tick
    task automatic setm(input logic [2:0] m);
        @(posedge clk);
        mode_wr <= 1'b1;
        mode_wdata <= m;
        @(posedge clk);
        mode_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : setm
    task automatic nsend(input logic [15:0] b, input logic [4:0] n);
        tick();
        go <= 1'b1;
        nbits <= b;
        nlen <= n;
        @(posedge clk);
        go <= 1'b0;
    endtask : nsend
    task automatic run_frame(input logic mid, output logic [6:0] v, output logic sof, output logic ok);
        int k;
        tick();
        tx_idx <= 5'h0;
        tx_n <= 5'h7;
        sof = 1'b0;
        ok = 1'b0;
        for (k = 0; k < 7; k++)
        begin
            tick();
            v = {v[5:0], can_tx};
            sof |= rx_out.sof;
            if (mid && k == 2)
            begin
                mode_wr <= 1'b1;
                mode_wdata <= 3'h4;
                @(posedge clk);
                mode_wr <= 1'b0;
            end
        end
        if (mid) chk({mode_pending, mode_active}, {1'b1, CMF_NORMAL});
        for (k = 0; k < 1000 && tx_done !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
            ok |= rx_out.frame_ok;
        end
        chk(tx_done, 1'b1);
    endtask : run_frame
    task automatic t_modes();
        logic [2:0] codes [5] = '{3'h0, 3'h6, 3'h1, 3'h2, 3'h5};
        cmf_mode_t m;
        foreach (codes[i])
        begin
            setm(codes[i]);
            m = codes[i][2] ? CMF_INIT : cmf_mode_t'(codes[i]);
            chk(mode_requested, m);
            chk(mode_active, m);
            chk({cfg_wr_enable, err_ctr_hold}, {m == CMF_INIT, m == CMF_INIT || m == CMF_MON});
        end
        $display("modes test done");
    endtask : t_modes
    task automatic t_frames();
        logic [6:0] v;
        logic s, e, c, o;
        logic [5:0] r;
        int k, n;
        setm(3'h0);
        run_frame(1'b1, v, s, o);
        chk({v, o}, {7'h02, 1'b1});
        repeat (3) @(posedge clk);
        #1;
        chk(mode_active, CMF_INIT);
        setm(3'h1);
        run_frame(1'b0, v, s, o);
        chk({v, s, o}, {7'h7f, 2'h3});
        setm(3'h2);
        nsend(16'h0600, 5'd7);
        {r, n, e, c} = {6'h0, 32'd0, 1'b0, 1'b1};
        for (k = 0; k < 25; k++)
        begin
            tick();
            if (rx_out.valid === 1'b1 && n < 6)
            begin
                r = {r[4:0], rx_out.bit_val};
                n++;
            end
            e |= rx_out.frame_err;
            c &= can_tx;
        end
        chk({r, e, c}, {6'h01, 2'h3});
        $display("frame test done");
    endtask : t_frames
    task automatic t_sleep();
        int k;
        tx_queue_empty <= 1'b0;
        setm(3'h3);
        chk({mode_pending, mode_active}, {1'b1, CMF_MON});
        tx_queue_empty <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(mode_active, CMF_SLEEP);
        wake <= 1'b1;
        nsend(16'h0, 5'd1);
        repeat (3) tick();
        chk({mode_pending, mode_active}, {1'b0, CMF_MON});
        wake <= 1'b0;
        repeat (12) tick();
        tick_div = 12;
        setm(3'h0);
        tick();
        tx_idx <= 5'h0;
        tx_n <= 5'h7;
        for (k = 0; k < 300 && tx_shutoff !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        chk({tx_shutoff, can_tx, k > 50}, 3'h7);
        $display("sleep and timeout test done");
    endtask : t_sleep
    task automatic results();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    initial
    begin
        {clk, sys_rst, mode_wr, wake, tx_queue_empty, bit_tick, go} = 7'h24;
        {mode_wdata, nbits, nlen, tx_idx, tx_n, tx_src, rxn} = '0;
        {tick_div, tcnt, n_errors, comparisons} = {32'd6, 96'd0};
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk({mode_active, cfg_wr_enable, err_ctr_hold, can_tx, tx_shutoff}, {CMF_INIT, 4'he});
        t_modes();
        t_frames();
        t_sleep();
        results();
    end
    // watchdog, runs far past the expected run of under a thousand cycles
    initial
    begin
        #400000;
        n_errors++;
        results();
    end
endmodule : can_mode_control_and_framing_tb
`default_nettype wire
